//--- bench/emi_mem_model.sv
// far-side static memory with wait generator
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model (
    // clock
    input wire logic ref_clk,
    // memory bus as seen on the wires
    input wire logic [15:0] addr,
    input wire logic sel_n,
    input wire logic [1:0] we_n,
    input wire logic [15:0] dq_o,
    input wire logic [1:0] dq_oe,
    output logic [15:0] dq,
    // handshakes
    input wire logic bsel,
    input wire logic [3:0] nwait,
    output logic wait_request,
    output logic byte_access_select,
    output logic [7:0] low_len
);
    logic [7:0] mem [0:65535];
    logic [7:0] cnt = 8'h00;
    logic [1:0] hold = 2'h3;
    logic rd_q = 1'b0;
    logic [15:0] junk = 16'h5a5a;
    logic [15:0] rd;
    assign byte_access_select = bsel;
    // high for nwait whole wait states, counted from select low
    assign wait_request = cnt < {2'h0, nwait, 2'h0};
    assign rd = bsel ? {junk[15:8], mem[addr]} : {mem[addr | 16'h0001], mem[addr & 16'hfffe]};
    always_comb begin
        dq = junk;
        if (rd_q && hold != 2'h3) dq = rd;
        if (!sel_n && &we_n) dq = rd;
        if (dq_oe[0]) dq[7:0] = dq_o[7:0];
        if (dq_oe[1]) dq[15:8] = dq_o[15:8];
    end
    always @(posedge ref_clk) begin
        junk <= {junk[14:0], ~junk[15]};
        if (!sel_n) begin
            cnt <= cnt + 8'h01;
            hold <= 2'h0;
            rd_q <= &we_n;
            if (bsel && !we_n[0]) mem[addr] <= dq_o[7:0];
            if (!bsel && !we_n[0]) mem[addr & 16'hfffe] <= dq_o[7:0];
            if (!bsel && !we_n[1]) mem[addr | 16'h0001] <= dq_o[15:8];
        end else begin
            if (cnt != 8'h00) low_len <= cnt;
            cnt <= 8'h00;
            if (hold != 2'h3) hold <= hold + 2'h1;
        end
    end
endmodule : emi_mem_model
`default_nettype wire

//--- bench/emi_top_tb.sv
// self-checking bench for the external memory interface
`timescale 1ns/1ns
`default_nettype none
module emi_top_tb;
    import emi_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic req_ext = 1'b0;
    logic req_write = 1'b0;
    logic [14:0] req_waddr = 15'h0000;
    logic [1:0] req_be = 2'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic dma = 1'b0;
    logic bsel = 1'b0;
    logic [3:0] nwait = 4'h0;
    logic int_op = 1'b0;
    logic dma_run = 1'b0;
    logic req_ready, resp_valid, pclk, a_oe, ce_n, ce_oe, we_oe, bacc, wreq, grant;
    logic [15:0] resp_rdata, a_o, d_o, d_i;
    logic [1:0] d_oe, we_n;
    logic [7:0] low_len;
    logic [7:0] exp_mem [0:65535];
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int int_len = -1;
    int run = -1;
    logic pclk_q = 1'b0;
    always #5 ref_clk = ~ref_clk;
    emi_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req_ext(req_ext),
        .req_write(req_write), .req_waddr(req_waddr), .req_be(req_be), .req_wdata(req_wdata),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
        .proc_clock_output(pclk), .ext_addr_bus_o(a_o), .ext_addr_bus_oe(a_oe),
        .ext_data_bus_i(d_i), .ext_data_bus_o(d_o), .ext_data_bus_oe(d_oe),
        .chip_enable_n_o(ce_n), .chip_enable_n_oe(ce_oe), .byte_write_enables_n_o(we_n),
        .byte_write_enables_n_oe(we_oe), .byte_access_select(bacc), .wait_request(wreq),
        .dma_request(dma), .dma_grant(grant));
    // released strobes are pulled high
    emi_mem_model i_mem (.ref_clk(ref_clk), .addr(a_o), .sel_n(ce_oe ? ce_n : 1'b1),
        .we_n(we_oe ? we_n : 2'h3), .dq_o(d_o), .dq_oe(d_oe), .dq(d_i), .bsel(bsel),
        .nwait(nwait), .wait_request(wreq), .byte_access_select(bacc), .low_len(low_len));
    task automatic stop_test;
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [15:0] exp_len(input logic [3:0] nw);
        return 16'(2 * TSTATE_CYC * (1 + int'(nw)));
    endfunction : exp_len
    function automatic logic [15:0] exp_word(input logic [14:0] wa);
        return {exp_mem[{wa, 1'b1}], exp_mem[{wa, 1'b0}]};
    endfunction : exp_word
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end
    // strobe watch, mid-cycle
    always @(negedge ref_clk) begin
        if (!rstn) begin
            run = -1;
        end else if (pclk !== pclk_q) begin
            if (run > 0) chk("pclk half period", run[15:0], 16'(TSTATE_CYC));
            run = 1;
        end else if (run >= 0) begin
            run++;
        end
        pclk_q = pclk;
        if (rstn && int_op && we_oe) begin
            chk("internal strobes", {13'h0, ce_n, we_n}, 16'h0007);
            chk("internal data oe", {14'h0, d_oe}, 16'h0000);
        end
        if (rstn && req_write && !bsel && !ce_n && ce_oe) begin
            chk("write enables", {14'h0, we_n}, {14'h0, ~req_be});
            chk("write lanes", {14'h0, d_oe}, {14'h0, req_be});
        end
        if (rstn && !req_write && req_ext && we_oe) begin
            chk("read strobes", {12'h0, we_n, d_oe}, 16'h000c);
        end
        if (rstn && !ce_n && ce_oe) chk("address", {1'b0, a_o[15:1]}, {1'b0, req_waddr});
    end
    task automatic op(input logic ext, input logic wr, input logic [14:0] wa,
                      input logic [1:0] be, input logic [15:0] wd, input logic bs,
                      input logic [3:0] nw);
        int len;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_ext = ext;
        req_write = wr;
        req_waddr = wa;
        req_be = be;
        req_wdata = wd;
        bsel = bs;
        nwait = nw;
        int_op = !ext;
        while (req_ready !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        len = 0;
        while (resp_valid !== 1'b1) begin
            @(negedge ref_clk);
            len++;
        end
        int_op = 1'b0;
        if (!ext) begin
            chk("internal data", resp_rdata, 16'h0000);
            if (int_len < 0) int_len = len;
            chk("internal time", len[15:0], int_len[15:0]);
        end else begin
            if (!dma_run) chk("select length", {8'h0, low_len}, exp_len(nw));
            if (!wr) chk("read data", resp_rdata, exp_word(wa));
            if (wr && be[0]) exp_mem[{wa, 1'b0}] = wd[7:0];
            if (wr && be[1]) exp_mem[{wa, 1'b1}] = wd[15:8];
        end
    endtask : op
    task automatic dma_take(input int pre);
        int n;
        repeat (pre) @(negedge ref_clk);
        dma = 1'b1;
        n = 0;
        while (grant !== 1'b1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk("grant", {15'h0, grant}, 16'h0001);
        chk("bus float", {11'h0, a_oe, ce_oe, we_oe, d_oe}, 16'h0000);
        repeat (8) @(negedge ref_clk);
        dma = 1'b0;
        n = 0;
        while (grant !== 1'b0 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk("grant drop", {15'h0, grant}, 16'h0000);
    endtask : dma_take
    initial begin
        void'($urandom(32'h5633));
        repeat (6) @(negedge ref_clk);
        chk("reset state", {10'h0, ce_n, we_n, d_oe, grant}, 16'h0038);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) op(1'b1, 1'b1, 15'(i), 2'h3, 16'($urandom), 1'b0, 4'h0);
        // byte mode writes of each lane choice, with zero to two waits
        for (int b = 1; b < 4; b++) begin
            op(1'b1, 1'b1, 15'(b), 2'(b), 16'($urandom), 1'b1, 4'(b - 1));
            op(1'b1, 1'b0, 15'(b), 2'h3, 16'h0000, 1'b1, 4'h1);
            op(1'b1, 1'b0, 15'(b), 2'h3, 16'h0000, 1'b0, 4'h0);
        end
        op(1'b0, 1'b0, 15'h0005, 2'h3, 16'h0000, 1'b0, 4'h0);
        op(1'b0, 1'b1, 15'h0006, 2'h3, 16'h1234, 1'b0, 4'h3);
        for (int i = 0; i < 60; i++) begin
            op(($urandom % 4) != 0, 1'($urandom % 2), 15'($urandom % 8), 2'(1 + $urandom % 3),
               16'($urandom), 1'($urandom % 2), 4'($urandom % 3));
        end
        dma_take(2);
        dma_run = 1'b1;
        fork
            op(1'b1, 1'b0, 15'h0003, 2'h3, 16'h0000, 1'b0, 4'h2);
            dma_take(5);
        join
        dma_run = 1'b0;
        op(1'b1, 1'b0, 15'h0004, 2'h3, 16'h0000, 1'b1, 4'h0);
        stop_test();
    end
endmodule : emi_top_tb
`default_nettype wire

//--- rtl/emi_clk_if.sv
// half-period phase timing shared between divider and sequencer
`timescale 1ns/1ns
`default_nettype none
interface emi_clk_if;
    logic tick;
    logic next_high;
    modport gen (output tick, output next_high);
    modport use_side (input tick, input next_high);
endinterface : emi_clk_if
`default_nettype wire

//--- rtl/emi_pclk_gen.sv
// divider producing one enable pulse at the end of every t-state
`timescale 1ns/1ns
`default_nettype none
module emi_pclk_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // phase timing
    emi_clk_if.gen ph
);
    import emi_pkg::*;

    typedef struct packed {
        logic [TSTATE_CNT_W-1:0] cnt;
        logic high;
    } emi_div_s;

    emi_div_s div_q;
    emi_div_s div_d;

    always_comb begin
        div_d = div_q;
        if (div_q.cnt == TSTATE_CNT_W'(TSTATE_CYC - 1)) begin
            div_d.cnt = '0;
            div_d.high = ~div_q.high;
        end else begin
            div_d.cnt = div_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // reset phase is low, so the first tick leads into a high phase
    assign ph.tick = (div_q.cnt == TSTATE_CNT_W'(TSTATE_CYC - 1));
    assign ph.next_high = ~div_q.high;
endmodule : emi_pclk_gen
`default_nettype wire

//--- rtl/emi_pkg.sv
// shared constants and types for the external memory interface
package emi_pkg;
    // reference clock and processor clock timing
    localparam int REF_CLK_PERIOD_NS = 10;
    localparam int CLOCK_INPUT_PERIOD_NS = 200;
    localparam int CLOCK_MULTIPLIER_FACTOR = 5;
    localparam int PROC_CLOCK_PERIOD_NS = CLOCK_INPUT_PERIOD_NS / CLOCK_MULTIPLIER_FACTOR;
    localparam int TSTATE_NS = PROC_CLOCK_PERIOD_NS / 2;
    localparam int TSTATE_CYC = (TSTATE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int TSTATE_CNT_W = 4;

    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;

    // values after reset
    localparam logic [1:0] WE_IDLE = 2'h3;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    typedef enum logic [3:0] {
        EMI_IDLE,
        EMI_T1,
        EMI_T2,
        EMI_W1,
        EMI_W2,
        EMI_T3,
        EMI_T4,
        EMI_INT_H,
        EMI_INT_L,
        EMI_DMA_FLT,
        EMI_DMA,
        EMI_DMA_END
    } emi_state_e;

    typedef struct packed {
        emi_state_e state;
        logic pclk;
        logic [15:0] addr;
        logic aoe;
        logic ce_n;
        logic [1:0] we_n;
        logic [15:0] dout;
        logic doe_lo;
        logic doe_hi;
        logic grant;
        logic pend;
        logic r_ext;
        logic r_wr;
        logic [14:0] r_waddr;
        logic [1:0] r_be;
        logic [15:0] r_wd;
        logic bacc;
        logic second;
        logic dma_seen;
        logic dma_pend;
        logic [15:0] rdata;
        logic resp;
        logic ready;
    } emi_state_s;
endpackage : emi_pkg

//--- rtl/emi_sync.sv
// two-flop synchroniser for the asynchronous dma request
`timescale 1ns/1ns
`default_nettype none
module emi_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // level in and out
    input wire logic din,
    output logic dout
);
    import emi_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
    } emi_sync_s;

    emi_sync_s sy_q;
    emi_sync_s sy_d;

    always_comb begin
        sy_d.s1 = din;
        sy_d.s2 = sy_q.s1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sy_q <= '0;
        end else begin
            sy_q <= sy_d;
        end
    end

    assign dout = sy_q.s2;
endmodule : emi_sync
`default_nettype wire

//--- rtl/emi_top.sv
// external static memory interface sequencer with dma hand-over
// Summary of operation
// - each external cycle runs T1 setup, T2 data setup, T3 transfer, T4 hold.
// - each t-state is half a processor clock; T1 starts on a rising edge.
// - T2 may be stretched indefinitely by whole-period wait states.
// - internal cycles show word address, strobes inactive, data bus floating.
// - 16-bit address valid from T1 start until T4 end.
// - reads fetch full width; writes select bytes by write enables.
// - write data driven from T2 start until T4 end.
// - data bus floats except when writing; unused byte lane floats too.
// - one active-low write enable per lane; enable zero is low byte.
// - write enables track chip enable and rise between back-to-back writes.
// - write enables float during dma and stay inactive on internal cycles.
// - chip enable goes low on both external reads and writes.
// - word access by default; byte access select latched during T2.
// - byte mode splits word: low byte A0 low, high byte A0 high.
// - wait request sampled in T2; waits inserted after T2.
// - internal cycles ignore the wait request.
// - dma request sampled first high phase after chip enable falls, else rising edges.
// - address, data, write enables and chip enable float before grant rises.
// - strobe edges are timed from processor clock edges.
// - processor clock period is one microcode cycle derived from input clock.
// - second byte-mode read cycle: enables high, A0 high, upper lane floats.
// - wait re-sampled in W2; another wait while still high.
// - dma release sampled on rising edge; grant drops, bus resumes in low phase.
`timescale 1ns/1ns
`default_nettype none
module emi_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // core request port
    input wire logic req_valid,
    input wire logic req_ext,
    input wire logic req_write,
    input wire logic [14:0] req_waddr,
    input wire logic [1:0] req_be,
    input wire logic [emi_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic resp_valid,
    output logic [emi_pkg::DATA_W-1:0] resp_rdata,
    // processor clock
    output logic proc_clock_output,
    // address bus
    output logic [emi_pkg::ADDR_W-1:0] ext_addr_bus_o,
    output logic ext_addr_bus_oe,
    // data bus
    input wire logic [emi_pkg::DATA_W-1:0] ext_data_bus_i,
    output logic [emi_pkg::DATA_W-1:0] ext_data_bus_o,
    output logic [1:0] ext_data_bus_oe,
    // strobes
    output logic chip_enable_n_o,
    output logic chip_enable_n_oe,
    output logic [1:0] byte_write_enables_n_o,
    output logic byte_write_enables_n_oe,
    // memory handshakes
    input wire logic byte_access_select,
    input wire logic wait_request,
    // dma
    input wire logic dma_request,
    output logic dma_grant
);
    import emi_pkg::*;

    emi_state_s s_q;
    emi_state_s s_d;
    logic dreq;
    logic rise;

    emi_clk_if ph ();

    emi_pclk_gen u_pclk (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ph(ph.gen)
    );

    emi_sync u_dreq (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .din(dma_request),
        .dout(dreq)
    );

    assign rise = ph.tick && ph.next_high;

    always_comb begin
        s_d = s_q;
        s_d.resp = 1'b0;
        if (req_valid && s_q.ready) begin
            s_d.pend = 1'b1;
            s_d.r_ext = req_ext;
            s_d.r_wr = req_write;
            s_d.r_waddr = req_waddr;
            s_d.r_be = req_be;
            s_d.r_wd = req_wdata;
        end
        if (ph.tick) begin
            s_d.pclk = ph.next_high;
            case (s_q.state)
                EMI_IDLE: begin
                    if (rise && (dreq || s_q.dma_pend)) begin
                        s_d.state = EMI_DMA_FLT;
                        s_d.aoe = 1'b0;
                    end else if (rise && s_q.pend && s_q.r_ext) begin
                        s_d.state = EMI_T1;
                        s_d.addr = {s_q.r_waddr, 1'b0};
                        s_d.second = 1'b0;
                        s_d.bacc = 1'b0;
                        s_d.dma_seen = 1'b0;
                    end else if (rise && s_q.pend) begin
                        s_d.state = EMI_INT_H;
                        s_d.addr = {s_q.r_waddr, 1'b0};
                        s_d.second = 1'b0;
                    end
                end
                EMI_T1: begin
                    s_d.state = EMI_T2;
                    s_d.ce_n = 1'b0;
                    if (s_q.r_wr && !s_q.second) begin
                        s_d.we_n = ~s_q.r_be;
                        s_d.dout = s_q.r_wd;
                        s_d.doe_lo = s_q.r_be[0];
                        s_d.doe_hi = s_q.r_be[1];
                    end else if (s_q.r_wr) begin
                        s_d.we_n = s_q.r_be[1] ? 2'h0 : WE_IDLE;
                        s_d.dout = {8'h00, s_q.r_wd[15:8]};
                        s_d.doe_lo = s_q.r_be[1];
                        s_d.doe_hi = 1'b0;
                    end else begin
                        s_d.we_n = WE_IDLE;
                    end
                end
                EMI_T2: begin
                    if (!s_q.second) begin
                        s_d.bacc = byte_access_select;
                    end
                    s_d.state = wait_request ? EMI_W1 : EMI_T3;
                end
                EMI_W1: begin
                    s_d.state = EMI_W2;
                end
                EMI_W2: begin
                    s_d.state = wait_request ? EMI_W1 : EMI_T3;
                end
                EMI_T3: begin
                    s_d.state = EMI_T4;
                    s_d.ce_n = 1'b1;
                    s_d.we_n = WE_IDLE;
                end
                EMI_T4: begin
                    if (!s_q.r_wr && s_q.second) begin
                        s_d.rdata[15:8] = ext_data_bus_i[7:0];
                    end else if (!s_q.r_wr && s_q.bacc) begin
                        s_d.rdata = {8'h00, ext_data_bus_i[7:0]};
                    end else if (!s_q.r_wr) begin
                        s_d.rdata = ext_data_bus_i;
                    end
                    s_d.doe_lo = 1'b0;
                    s_d.doe_hi = 1'b0;
                    if (s_q.bacc && !s_q.second) begin
                        s_d.state = EMI_T1;
                        s_d.addr = {s_q.r_waddr, 1'b1};
                        s_d.second = 1'b1;
                        s_d.dma_seen = 1'b0;
                    end else begin
                        s_d.resp = 1'b1;
                        s_d.pend = 1'b0;
                        s_d.state = s_q.dma_pend ? EMI_DMA_FLT : EMI_IDLE;
                        s_d.aoe = ~s_q.dma_pend;
                    end
                end
                EMI_INT_H: begin
                    s_d.state = EMI_INT_L;
                end
                EMI_INT_L: begin
                    s_d.resp = 1'b1;
                    s_d.pend = 1'b0;
                    s_d.rdata = ZERO_WORD;
                    s_d.state = dreq ? EMI_DMA_FLT : EMI_IDLE;
                    s_d.aoe = ~dreq;
                end
                EMI_DMA_FLT: begin
                    s_d.grant = 1'b1;
                    s_d.dma_pend = 1'b0;
                    s_d.state = EMI_DMA;
                end
                EMI_DMA: begin
                    if (rise && !dreq) begin
                        s_d.grant = 1'b0;
                        s_d.state = EMI_DMA_END;
                    end
                end
                EMI_DMA_END: begin
                    s_d.state = EMI_IDLE;
                    s_d.aoe = 1'b1;
                end
                default: begin
                    s_d.state = EMI_IDLE;
                end
            endcase
            // first high phase after chip enable falls
            if ((s_q.state == EMI_W1 || s_q.state == EMI_T3) && !s_q.dma_seen) begin
                s_d.dma_seen = 1'b1;
                s_d.dma_pend = dreq;
            end
        end
        s_d.ready = !s_d.pend && (s_d.state == EMI_IDLE);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.state <= EMI_IDLE;
            s_q.aoe <= 1'b1;
            s_q.ce_n <= 1'b1;
            s_q.we_n <= WE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready = s_q.ready;
    assign resp_valid = s_q.resp;
    assign resp_rdata = s_q.rdata;
    assign proc_clock_output = s_q.pclk;
    assign ext_addr_bus_o = s_q.addr;
    assign ext_addr_bus_oe = s_q.aoe;
    assign ext_data_bus_o = s_q.dout;
    assign ext_data_bus_oe = {s_q.doe_hi, s_q.doe_lo};
    assign chip_enable_n_o = s_q.ce_n;
    assign chip_enable_n_oe = s_q.aoe;
    assign byte_write_enables_n_o = s_q.we_n;
    assign byte_write_enables_n_oe = s_q.aoe;
    assign dma_grant = s_q.grant;

    // checks
    property p_t1_on_rise;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.state != EMI_T1) ##1 (s_q.state == EMI_T1) |-> s_q.pclk;
    endproperty
    a_t1_on_rise: assert property (p_t1_on_rise) else $error("t1 not in high phase");

    property p_ce_only_external;
        @(posedge ref_clk) disable iff (!rstn)
        !s_q.ce_n |-> (s_q.state inside {EMI_T2, EMI_W1, EMI_W2, EMI_T3});
    endproperty
    a_ce_only_external: assert property (p_ce_only_external) else $error("chip enable bad");

    property p_internal_quiet;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.state inside {EMI_INT_H, EMI_INT_L}) |->
            (s_q.ce_n && s_q.we_n == WE_IDLE && !s_q.doe_lo && !s_q.doe_hi && s_q.aoe);
    endproperty
    a_internal_quiet: assert property (p_internal_quiet) else $error("internal cycle drives");

    property p_float_before_grant;
        @(posedge ref_clk) disable iff (!rstn)
        $rose(s_q.grant) |-> !s_q.aoe && !$past(s_q.aoe) && !s_q.doe_lo && !s_q.doe_hi;
    endproperty
    a_float_before_grant: assert property (p_float_before_grant) else $error("grant before float");

    property p_we_follow_ce;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.we_n != WE_IDLE) |-> !s_q.ce_n && s_q.r_wr;
    endproperty
    a_we_follow_ce: assert property (p_we_follow_ce) else $error("write enable outside ce");

    property p_write_data_window;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.doe_lo || s_q.doe_hi) |->
            (s_q.r_wr && s_q.state inside {EMI_T2, EMI_W1, EMI_W2, EMI_T3, EMI_T4});
    endproperty
    a_write_data_window: assert property (p_write_data_window) else $error("data driven late");

    property p_second_byte;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.second && s_q.state != EMI_IDLE) |-> s_q.addr[0] && !s_q.doe_hi;
    endproperty
    a_second_byte: assert property (p_second_byte) else $error("second byte cycle wrong");

    property p_wait_extends;
        @(posedge ref_clk) disable iff (!rstn)
        (ph.tick && s_q.state == EMI_T2 && wait_request) |=> (s_q.state == EMI_W1);
    endproperty
    a_wait_extends: assert property (p_wait_extends) else $error("wait not inserted");

    property p_addr_stable;
        @(posedge ref_clk) disable iff (!rstn)
        (s_q.state inside {EMI_T2, EMI_W1, EMI_W2, EMI_T3, EMI_T4}) |-> $stable(s_q.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved mid cycle");

    property p_resume_low;
        @(posedge ref_clk) disable iff (!rstn)
        $fell(s_q.grant) |-> !s_q.aoe ##1 (!s_q.aoe)[*1] ##[0:16] s_q.aoe && !s_q.pclk;
    endproperty
    a_resume_low: assert property (p_resume_low) else $error("bus resumed badly");
endmodule : emi_top
`default_nettype wire
